// *** shared/dcudc_pkg.sv ***
// constants and pin carrier for the dual clock up/down counter
package dcudc_pkg;
  localparam int          CNT_W       = 4;
  localparam logic [3:0]  CNT_MAX     = 4'hf;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  localparam logic [3:0]  CNT_ONE     = 4'h1;
  localparam logic [3:0]  CNT_RST     = 4'h0;

  // register port
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 8;
  localparam logic [3:0]  REG_STATUS  = 4'h0;
  localparam logic [3:0]  REG_MASK    = 4'h4;
  localparam logic [3:0]  REG_COUNT   = 4'h8;

  // status and mask layout
  localparam int          ST_W        = 4;
  localparam int          ST_WRAP_UP  = 0;
  localparam int          ST_WRAP_DN  = 1;
  localparam int          ST_PRESET   = 2;
  localparam int          ST_CLEAR    = 3;
  localparam logic [3:0]  STATUS_RST  = 4'h0;
  localparam logic [3:0]  MASK_RST    = 4'h0;

  typedef struct packed {
    logic       up_clk;
    logic       dn_clk;
    logic       preset_n;
    logic       clear;
    logic [3:0] preset_value;
  } dcudc_pins_s;

  // idle pin levels: both clocks high, no preset, no clear
  localparam logic [7:0]  PINS_IDLE   = 8'he0;
endpackage

// *** design/dcudc_counter.sv ***
// dual clock up/down 4-bit counter with preset, clear, status and interrupt
// Function
// - four-bit binary state shown on outputs
// - up clock rise, down high: increment
// - down clock rise, up high: decrement
// - carry and borrow rest high
// - at fifteen carry mirrors up clock
// - at zero borrow mirrors down clock
// - preset low loads data inputs
// - clear forces zero, beats preset, clocks
// - clock low through load counts next rise
module dcudc_counter (
  input  wire logic                        ref_clk,
  input  wire logic                        reset_n,
  input  wire logic                        count_up_clock,
  input  wire logic                        count_down_clock,
  input  wire logic                        preset_n,
  input  wire logic                        clear_in,
  input  wire logic [dcudc_pkg::CNT_W-1:0] preset_value,
  input  wire logic [dcudc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [dcudc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [dcudc_pkg::DATA_W-1:0] reg_rdata,
  output logic      [dcudc_pkg::CNT_W-1:0] count_value,
  output logic                             carry_out_n,
  output logic                             borrow_out_n,
  output logic                             irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pins are asynchronous to ref_clk; the first stage is read only by the second
  dcudc_pkg::dcudc_pins_s pins_in;
  dcudc_pkg::dcudc_pins_s meta_r;
  dcudc_pkg::dcudc_pins_s sync_r;
  dcudc_pkg::dcudc_pins_s prev_r;

  assign pins_in.up_clk       = count_up_clock;
  assign pins_in.dn_clk       = count_down_clock;
  assign pins_in.preset_n     = preset_n;
  assign pins_in.clear        = clear_in;
  assign pins_in.preset_value = preset_value;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta_r <= dcudc_pkg::PINS_IDLE;
      sync_r <= dcudc_pkg::PINS_IDLE;
      prev_r <= dcudc_pkg::PINS_IDLE;
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // ----------------------------------------------------------------
  // count decode
  // ----------------------------------------------------------------
  logic [dcudc_pkg::CNT_W-1:0] count_r;
  logic [dcudc_pkg::CNT_W-1:0] count_nxt;
  wire                         clr_s      = sync_r.clear;
  wire                         load_s     = !sync_r.preset_n && !clr_s;
  wire                         hold_async = clr_s || !sync_r.preset_n;
  // edge history runs through clear and load, so a clock held low across
  // either still counts on its next rise
  wire                         up_rise    = sync_r.up_clk && !prev_r.up_clk;
  wire                         dn_rise    = sync_r.dn_clk && !prev_r.dn_clk;
  // a rise while the other clock is low is dropped: "not at all" is the
  // safer of the two outcomes the part allows
  wire                         do_up      = up_rise && sync_r.dn_clk && !hold_async;
  wire                         do_dn      = dn_rise && sync_r.up_clk && !hold_async;
  wire                         wrap_up    = do_up && (count_r == dcudc_pkg::CNT_MAX);
  wire                         wrap_dn    = do_dn && (count_r == dcudc_pkg::CNT_ZERO);

  always_comb begin
    count_nxt = count_r;
    if (clr_s) begin
      count_nxt = dcudc_pkg::CNT_ZERO;
    end else if (load_s) begin
      count_nxt = sync_r.preset_value;
    end else if (do_up) begin
      count_nxt = count_r + dcudc_pkg::CNT_ONE;
    end else if (do_dn) begin
      count_nxt = count_r - dcudc_pkg::CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // terminal decode
  // ----------------------------------------------------------------
  // active-low flag: low only at the target state while its clock is low,
  // so a chained stage sees a copy of this stage's clock
  function automatic logic term_n(input logic [dcudc_pkg::CNT_W-1:0] state,
                                  input logic [dcudc_pkg::CNT_W-1:0] target,
                                  input logic                        clk_level);
    term_n = !((state == target) && !clk_level);
  endfunction

  // terminal outputs follow the new state and current clock level, also
  // during clear and load; pin to carry latency is three ref_clk cycles
  wire carry_nxt  = term_n(count_nxt, dcudc_pkg::CNT_MAX, sync_r.up_clk);
  wire borrow_nxt = term_n(count_nxt, dcudc_pkg::CNT_ZERO, sync_r.dn_clk);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_r      <= dcudc_pkg::CNT_RST;
      carry_out_n  <= 1'b1;
      borrow_out_n <= 1'b1;
    end else begin
      count_r      <= count_nxt;
      carry_out_n  <= carry_nxt;
      borrow_out_n <= borrow_nxt;
    end
  end

  assign count_value = count_r;

  // ----------------------------------------------------------------
  // status, mask and interrupt
  // ----------------------------------------------------------------
  logic [dcudc_pkg::ST_W-1:0] status_r;
  logic [dcudc_pkg::ST_W-1:0] status_nxt;
  logic [dcudc_pkg::ST_W-1:0] mask_r;
  logic [dcudc_pkg::ST_W-1:0] mask_nxt;
  logic [dcudc_pkg::ST_W-1:0] events;

  wire sel_status = (reg_addr == dcudc_pkg::REG_STATUS);
  wire sel_mask   = (reg_addr == dcudc_pkg::REG_MASK);
  wire sel_count  = (reg_addr == dcudc_pkg::REG_COUNT);

  assign events[dcudc_pkg::ST_WRAP_UP] = wrap_up;
  assign events[dcudc_pkg::ST_WRAP_DN] = wrap_dn;
  assign events[dcudc_pkg::ST_PRESET]  = load_s && prev_r.preset_n;
  assign events[dcudc_pkg::ST_CLEAR]   = clr_s && !prev_r.clear;

  wire [dcudc_pkg::ST_W-1:0] w1c = (reg_wr && sel_status) ? reg_wdata[dcudc_pkg::ST_W-1:0] : '0;

  // a new event in the cycle of its clear keeps the bit set
  assign status_nxt = (status_r & ~w1c) | events;
  assign mask_nxt   = (reg_wr && sel_mask) ? reg_wdata[dcudc_pkg::ST_W-1:0] : mask_r;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      status_r <= dcudc_pkg::STATUS_RST;
      mask_r   <= dcudc_pkg::MASK_RST;
      irq      <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq      <= |(status_nxt & mask_nxt);
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // unmapped addresses read zero; data stand one cycle only
  wire [dcudc_pkg::DATA_W-1:0] rd_mux =
    sel_status ? {{(dcudc_pkg::DATA_W-dcudc_pkg::ST_W){1'b0}}, status_r} :
    sel_mask   ? {{(dcudc_pkg::DATA_W-dcudc_pkg::ST_W){1'b0}}, mask_r} :
    sel_count  ? {{(dcudc_pkg::DATA_W-dcudc_pkg::CNT_W){1'b0}}, count_r} :
    '0;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_clear_zero: assert property (clr_s |=> count_value == dcudc_pkg::CNT_ZERO)
    else $error("clear did not zero the count");

  a_preset_load: assert property (load_s |=> count_value == $past(sync_r.preset_value))
    else $error("preset did not load the data inputs");

  a_count_up: assert property (do_up |=> count_value == $past(count_value) + dcudc_pkg::CNT_ONE)
    else $error("up edge did not increment");

  a_count_down: assert property (do_dn |=> count_value == $past(count_value) - dcudc_pkg::CNT_ONE)
    else $error("down edge did not decrement");

  a_idle_hold: assert property (!up_rise && !dn_rise && !hold_async |=> $stable(count_value))
    else $error("count moved without a cause");

  a_wrap_up_zero: assert property (wrap_up |=> count_value == dcudc_pkg::CNT_ZERO
                                   ##0 status_r[dcudc_pkg::ST_WRAP_UP])
    else $error("up wrap did not reach zero or flag");

  a_wrap_dn_max: assert property (wrap_dn |=> count_value == dcudc_pkg::CNT_MAX
                                  ##0 status_r[dcudc_pkg::ST_WRAP_DN])
    else $error("down wrap did not reach fifteen or flag");

  a_carry_mirror: assert property (count_value != dcudc_pkg::CNT_MAX |-> carry_out_n)
    else $error("carry low away from fifteen");

  a_carry_follow: assert property (count_nxt == dcudc_pkg::CNT_MAX && !sync_r.up_clk |=> !carry_out_n)
    else $error("carry did not follow low up clock at fifteen");

  a_borrow_mirror: assert property (count_value != dcudc_pkg::CNT_ZERO |-> borrow_out_n)
    else $error("borrow low away from zero");

  a_borrow_follow: assert property (clr_s && !sync_r.dn_clk |=> !borrow_out_n)
    else $error("borrow not decoded during clear");

  a_irq_level: assert property (irq == |(status_r & mask_r))
    else $error("interrupt does not match masked status");

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  a_meta_capture: assert property (meta_r == $past(pins_in))
    else $error("first pin stage did not capture the pins");

  a_sync_chain: assert property (sync_r == $past(meta_r))
    else $error("second pin stage did not follow the first");

  a_prev_chain: assert property (prev_r == $past(sync_r))
    else $error("edge history did not follow the second stage");

  // ----------------------------------------------------------------
  // terminal outputs
  // ----------------------------------------------------------------
  a_carry_rest: assert property (count_nxt != dcudc_pkg::CNT_MAX |=> carry_out_n)
    else $error("carry left its resting level away from fifteen");

  a_borrow_rest: assert property (count_nxt != dcudc_pkg::CNT_ZERO |=> borrow_out_n)
    else $error("borrow left its resting level away from zero");

  a_carry_high_clk: assert property (sync_r.up_clk |=> carry_out_n)
    else $error("carry low while the up clock is high");

  a_borrow_high_clk: assert property (sync_r.dn_clk |=> borrow_out_n)
    else $error("borrow low while the down clock is high");

  a_borrow_at_zero: assert property (count_nxt == dcudc_pkg::CNT_ZERO && !sync_r.dn_clk |=> !borrow_out_n)
    else $error("borrow did not follow low down clock at zero");

  // ----------------------------------------------------------------
  // clear, load and refused edges
  // ----------------------------------------------------------------
  a_clear_beats_load: assert property (clr_s && !sync_r.preset_n |=> count_value == dcudc_pkg::CNT_ZERO)
    else $error("preset was not blocked by clear");

  a_clear_no_count: assert property (clr_s |-> !do_up && !do_dn)
    else $error("a clock edge counted during clear");

  a_load_no_count: assert property (!sync_r.preset_n |-> !do_up && !do_dn)
    else $error("a clock edge counted during preset");

  a_up_refused: assert property (up_rise && !sync_r.dn_clk && !hold_async |=> $stable(count_value))
    else $error("up edge counted while the down clock was low");

  a_dn_refused: assert property (dn_rise && !sync_r.up_clk && !hold_async |=> $stable(count_value))
    else $error("down edge counted while the up clock was low");

  a_preset_once: assert property (events[dcudc_pkg::ST_PRESET] |=> !events[dcudc_pkg::ST_PRESET])
    else $error("preset event raised for more than one cycle");

  a_clear_once: assert property (events[dcudc_pkg::ST_CLEAR] |=> !events[dcudc_pkg::ST_CLEAR])
    else $error("clear event raised for more than one cycle");

  // ----------------------------------------------------------------
  // status bits, mask and interrupt
  // ----------------------------------------------------------------
  // the same four checks for every status bit
  for (genvar k = 0; k < dcudc_pkg::ST_W; k++) begin : g_status_chk
    a_event_sets: assert property (events[k] |=> status_r[k])
      else $error("event did not set its status bit");
    a_status_hold: assert property (status_r[k] && !w1c[k] |=> status_r[k])
      else $error("status bit dropped without a clear");
    a_status_clear: assert property (w1c[k] && !events[k] |=> !status_r[k])
      else $error("status bit survived its clear");
    a_status_idle: assert property (!status_r[k] && !events[k] |=> !status_r[k])
      else $error("status bit set without an event");
  end

  a_mask_write: assert property (reg_wr && sel_mask |=> mask_r == $past(reg_wdata[dcudc_pkg::ST_W-1:0]))
    else $error("mask write did not land");

  a_mask_hold: assert property (!(reg_wr && sel_mask) |=> $stable(mask_r))
    else $error("mask changed without a write");

  a_irq_rise: assert property (|(status_nxt & mask_nxt) |=> irq)
    else $error("interrupt did not rise on an unmasked bit");

  a_irq_fall: assert property (!(|(status_nxt & mask_nxt)) |=> !irq)
    else $error("interrupt stayed high with nothing unmasked");

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data stood outside the read cycle");

  a_rdata_count: assert property (reg_rd && sel_count |=>
    reg_rdata == {{(dcudc_pkg::DATA_W-dcudc_pkg::CNT_W){1'b0}}, $past(count_value)})
    else $error("count read returned the wrong value");

  a_rdata_status: assert property (reg_rd && sel_status |=>
    reg_rdata == {{(dcudc_pkg::DATA_W-dcudc_pkg::ST_W){1'b0}}, $past(status_r)})
    else $error("status read returned the wrong value");

  a_rdata_mask: assert property (reg_rd && sel_mask |=>
    reg_rdata == {{(dcudc_pkg::DATA_W-dcudc_pkg::ST_W){1'b0}}, $past(mask_r)})
    else $error("mask read returned the wrong value");

  a_rdata_unmapped: assert property (reg_rd && !sel_status && !sel_mask && !sel_count |=> reg_rdata == '0)
    else $error("unmapped read returned nonzero data");

  a_rdata_top: assert property (reg_rdata[dcudc_pkg::DATA_W-1:dcudc_pkg::ST_W] == '0)
    else $error("upper read data bits not zero");

  c_wrap_up: cover property (wrap_up ##1 irq);
  c_wrap_dn: cover property (wrap_dn);
  c_preset:  cover property (load_s ##[1:20] do_up);
  c_clear_low_clock: cover property (clr_s && !sync_r.up_clk ##1 !clr_s ##[1:20] do_up);
  c_cascade_carry: cover property (!carry_out_n ##1 carry_out_n);

endmodule

// *** test/dcudc_driver.sv ***
// far-side logic model driving the counter's clock, preset and clear pins
module dcudc_driver (
  input  wire logic              ref_clk,
  input  wire logic              carry_n,
  output dcudc_pkg::dcudc_pins_s pins,
  output logic [3:0]             stage2
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pins = dcudc_pkg::PINS_IDLE;
  // -------------------------------------------------------------------------
  // pin levels
  // -------------------------------------------------------------------------
  // every level holds 5 cycles: the pin synchronisers miss anything under 1
  task automatic set(input logic up, dn, pn, clr, input logic [3:0] v);
    @(posedge ref_clk);
    pins <= '{up, dn, pn, clr, v};
    repeat (4) @(posedge ref_clk);
  endtask
  // idle clock stays high; direction only changes between pulses, both high
  task automatic pulse(input logic up, input int n);
    repeat (n) begin
      set(!up, up, 1'b1, 1'b0, ~pins.preset_value);
      set(1'b1, 1'b1, 1'b1, 1'b0, ~pins.preset_value);
    end
  endtask
  // next stage model: carry feeds its up clock, each rise counts once
  logic carry_q;
  initial begin
    carry_q = 1'b1;
    stage2  = 4'h0;
  end
  always @(posedge ref_clk) begin
    carry_q <= carry_n;
    if (carry_n && !carry_q) stage2 <= stage2 + 4'h1;
  end
endmodule

// *** test/dcudc_counter_test.sv ***
// self-checking bench for the dual clock up/down counter
module dcudc_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] op;
    logic [3:0] arg;
    logic [3:0] exp;
  } dcudc_row_s;
  logic                  ref_clk   = 1'b0;
  logic                  reset_n   = 1'b0;
  logic [3:0]            reg_addr  = 4'h0;
  logic [7:0]            reg_wdata = 8'h00;
  logic                  reg_wr    = 1'b0;
  logic                  reg_rd    = 1'b0;
  logic [7:0]            reg_rdata;
  logic [3:0]            count_value;
  logic                  carry_out_n;
  logic                  borrow_out_n;
  logic                  irq;
  dcudc_pkg::dcudc_pins_s pins;
  logic [3:0]            stage2;
  int                    num_errors = 0;
  int                    n_checks   = 0;
  int                    cycles     = 0;
  // ops: 0 load, 1 up pulses, 2 down pulses, 3 clear
  dcudc_row_s            rows [8]   = '{'{2'd0, 4'he, 4'he}, '{2'd1, 4'h1, 4'hf}, '{2'd1, 4'h1, 4'h0},
    '{2'd2, 4'h1, 4'hf}, '{2'd3, 4'h0, 4'h0}, '{2'd2, 4'h3, 4'hd}, '{2'd0, 4'h5, 4'h5}, '{2'd1, 4'h2, 4'h7}};

  dcudc_driver u_far (.ref_clk(ref_clk), .carry_n(carry_out_n), .pins(pins), .stage2(stage2));
  dcudc_counter u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .count_up_clock(pins.up_clk),
    .count_down_clock(pins.dn_clk), .preset_n(pins.preset_n), .clear_in(pins.clear),
    .preset_value(pins.preset_value), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_value(count_value), .carry_out_n(carry_out_n),
    .borrow_out_n(borrow_out_n), .irq(irq));

  initial forever #2.5 ref_clk = ~ref_clk;
  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask
  task automatic outs(input logic [3:0] c, input logic cy, input logic bw);
    #1;
    chk("count_value", {4'h0, count_value}, {4'h0, c});
    chk("carry_out_n", {7'h0, carry_out_n}, {7'h0, cy});
    chk("borrow_out_n", {7'h0, borrow_out_n}, {7'h0, bw});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    outs(4'h0, 1'b1, 1'b1);
    chk("irq", {7'h0, irq}, 8'h00);
    rd(dcudc_pkg::REG_STATUS, 8'h00);
    rd(dcudc_pkg::REG_MASK, 8'h00);
    foreach (rows[i]) begin
      case (rows[i].op)
        2'd0: begin
          u_far.set(1'b1, 1'b1, 1'b0, 1'b0, rows[i].arg);
          u_far.set(1'b1, 1'b1, 1'b1, 1'b0, ~rows[i].arg);
        end
        2'd1: u_far.pulse(1'b1, int'(rows[i].arg));
        2'd2: u_far.pulse(1'b0, int'(rows[i].arg));
        default: begin
          u_far.set(1'b1, 1'b1, 1'b1, 1'b1, 4'h3);
          u_far.set(1'b1, 1'b1, 1'b1, 1'b0, 4'hc);
        end
      endcase
      outs(rows[i].exp, 1'b1, 1'b1);
    end
    // preset while the up clock is low, then that clock's rise must count
    u_far.set(1'b0, 1'b1, 1'b1, 1'b0, 4'h3);
    u_far.set(1'b0, 1'b1, 1'b0, 1'b0, 4'hf);
    outs(4'hf, 1'b0, 1'b1);
    u_far.set(1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
    outs(4'hf, 1'b0, 1'b1);
    u_far.set(1'b1, 1'b1, 1'b1, 1'b0, 4'h5);
    outs(4'h0, 1'b1, 1'b1);
    // clear with the down clock low, clear beats preset, then the rise counts
    u_far.set(1'b1, 1'b0, 1'b1, 1'b0, 4'ha);
    outs(4'h0, 1'b1, 1'b0);
    u_far.set(1'b1, 1'b0, 1'b1, 1'b1, 4'h5);
    outs(4'h0, 1'b1, 1'b0);
    u_far.set(1'b1, 1'b0, 1'b0, 1'b1, 4'h9);
    outs(4'h0, 1'b1, 1'b0);
    u_far.set(1'b1, 1'b0, 1'b1, 1'b0, 4'h6);
    u_far.set(1'b1, 1'b1, 1'b1, 1'b0, 4'h9);
    outs(4'hf, 1'b1, 1'b1);
    // status, mask and interrupt
    rd(dcudc_pkg::REG_STATUS, 8'h0f);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(dcudc_pkg::REG_MASK, 8'hff);
    chk("irq", {7'h0, irq}, 8'h01);
    rd(dcudc_pkg::REG_MASK, 8'h0f);
    wr(dcudc_pkg::REG_STATUS, 8'h0f);
    chk("irq", {7'h0, irq}, 8'h00);
    rd(dcudc_pkg::REG_STATUS, 8'h00);
    wr(dcudc_pkg::REG_MASK, 8'h01);
    // clear and down wrap are masked, only the up wrap raises the interrupt
    u_far.set(1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
    u_far.set(1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
    u_far.pulse(1'b0, 1);
    chk("irq", {7'h0, irq}, 8'h00);
    u_far.pulse(1'b1, 1);
    chk("irq", {7'h0, irq}, 8'h01);
    chk("stage2", {4'h0, stage2}, 8'h03);
    rd(dcudc_pkg::REG_STATUS, 8'h0b);
    wr(dcudc_pkg::REG_STATUS, 8'h01);
    chk("irq", {7'h0, irq}, 8'h00);
    wr(4'hc, 8'h55);
    rd(4'hc, 8'h00);
    wr(dcudc_pkg::REG_COUNT, 8'h03);
    rd(dcudc_pkg::REG_COUNT, 8'h00);
    // reset in mid-run returns count, mask and outputs to idle
    u_far.pulse(1'b0, 1);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    outs(4'h0, 1'b1, 1'b1);
    chk("irq", {7'h0, irq}, 8'h00);
    rd(dcudc_pkg::REG_MASK, 8'h00);
    give_verdict();
  end
endmodule
